// *** acf_pkg.sv ***
/*
  Package for the conversion done flag block: register offsets,
  field positions, reset values and widths.
  Assumes a 32-bit APB slave with one aligned word per register.
*/
package acf_pkg;
  // ==========================================================
  // Sizes
  localparam int unsigned NUM_CHAN   = 16;
  localparam int unsigned HALF_CHAN  = 8;
  localparam int unsigned ADDR_W     = 12;
  // ==========================================================
  // Register byte offsets
  localparam logic [11:0] OFS_DONE_HIGH  = 12'h000;
  localparam logic [11:0] OFS_DONE_LOW   = 12'h004;
  localparam logic [11:0] OFS_DIEN_HIGH  = 12'h008;
  localparam logic [11:0] OFS_DIEN_LOW   = 12'h00c;
  localparam logic [11:0] OFS_PIN_HIGH   = 12'h010;
  localparam logic [11:0] OFS_PIN_LOW    = 12'h014;
  localparam logic [11:0] OFS_CTRL       = 12'h018;
  localparam logic [11:0] OFS_STATUS     = 12'h01c;
  localparam logic [11:0] OFS_SEQ_START  = 12'h020;
  localparam logic [11:0] OFS_RESULT0    = 12'h040;
  localparam logic [11:0] OFS_RESULT_END = 12'h080;
  // ==========================================================
  // Field positions
  localparam int unsigned CTRL_FAST_CLR_BIT = 0;
  localparam int unsigned STAT_OVERRUN_BIT  = 4;
  localparam int unsigned STAT_POS_LSB      = 0;
  localparam int unsigned STAT_OVERRUN_W1C  = 4;
  // ==========================================================
  // Reset values
  localparam logic [15:0] RST_DONE  = 16'h0000;
  localparam logic [15:0] RST_DIEN  = 16'h0000;
  localparam logic [15:0] RST_PIN   = 16'hffff;
  localparam logic [3:0]  RST_POS   = 4'h0;
  localparam logic [9:0]  RST_RES   = 10'h000;
endpackage

// *** acf_completion_flags.sv ***
/*
  Conversion done flags, result registers, digital input buffer
  enables and pin data for a 16 channel converter, behind APB.
  Assumes the converter core supplies a one-cycle end-of-conversion
  strobe with its 10-bit result, and the sequencer an external
  trigger channel select.
*/
`timescale 1ns/100ps

module acf_completion_flags (
  // Clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Converter core
  input  wire logic        convDone,
  input  wire logic [9:0]  convResult,
  input  wire logic        trigEnable,
  input  wire logic [3:0]  trigChannel,
  // Analog pins, digital side; sequence start pulse and fast clear mode out
  input  wire logic [15:0] analogInputPin,
  output logic      [15:0] inputBufferEnable,
  output logic             seqStartPulse,
  output logic             fastFlagClear
);

  // ==========================================================
  // Storage
  logic [15:0] doneFlag_ff;
  logic [15:0] armed_ff;
  logic [15:0] dien_ff;
  logic [15:0] pinSync1_ff, pinSync2_ff;
  logic [3:0]  seqPos_ff;
  logic        overrun_ff;
  logic        fastClr_ff;
  logic [9:0]  result_ff [16];
  logic [31:0] prdata_ff;
  logic        pready_ff;
  logic        pslverr_ff;
  logic        seqStart_ff;

  // ==========================================================
  // Bus decode
  logic        access;
  logic        wrEn;
  logic        rdEn;
  logic        resSel;
  logic [3:0]  resIdx;
  logic        seqWrite;
  logic [15:0] setMask;
  logic [15:0] rdClear;
  logic [15:0] pinView;

  // Register index from a result register address
  function automatic logic [3:0] res_index(input logic [11:0] a);
    logic [11:0] d;
    d = a - acf_pkg::OFS_RESULT0;
    return d[5:2];
  endfunction

  function automatic logic is_result(input logic [11:0] a);
    return a >= acf_pkg::OFS_RESULT0 && a < acf_pkg::OFS_RESULT_END
           && a[1:0] == 2'h0;
  endfunction

  // Zero wait states: the access edge is the one at which pready stands
  assign access   = psel && penable && pready_ff;
  assign wrEn     = access && pwrite;
  assign rdEn     = access && !pwrite;
  assign resSel   = is_result(paddr);
  assign resIdx   = res_index(paddr);
  assign seqWrite = wrEn && paddr == acf_pkg::OFS_SEQ_START;

  // One-hot set for the running position
  assign setMask = convDone ? (16'h0001 << seqPos_ff) : 16'h0000;

  // Read based clears, chosen by fast clear mode
  always_comb begin
    rdClear = 16'h0000;
    if (rdEn && resSel) begin
      if (fastClr_ff)
        rdClear[resIdx] = 1'b1;
      else
        rdClear[resIdx] = armed_ff[resIdx];
    end
  end

  // ==========================================================
  // Done flags: start clear wins, then set, then read clear
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      doneFlag_ff <= acf_pkg::RST_DONE;
    end else if (seqWrite) begin
      doneFlag_ff <= 16'h0000;
    end else begin
      doneFlag_ff <= (doneFlag_ff & ~rdClear) | setMask;
    end
  end

  // Arming: outside fast clear mode, a status read captures flags that are set at that moment
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      armed_ff <= 16'h0000;
    end else if (seqWrite || fastClr_ff) begin
      armed_ff <= 16'h0000;
    end else if (rdEn && paddr == acf_pkg::OFS_DONE_HIGH) begin
      armed_ff <= (armed_ff & ~rdClear) | {doneFlag_ff[15:8], 8'h00};
    end else if (rdEn && paddr == acf_pkg::OFS_DONE_LOW) begin
      armed_ff <= (armed_ff & ~rdClear) | {8'h00, doneFlag_ff[7:0]};
    end else if (rdEn && resSel) begin
      armed_ff[resIdx] <= 1'b0;
    end
  end

  // ==========================================================
  // Position counter and results
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      seqPos_ff <= acf_pkg::RST_POS;
    end else if (seqWrite) begin
      seqPos_ff <= acf_pkg::RST_POS;
    end else if (convDone) begin
      seqPos_ff <= seqPos_ff + 4'h1;
    end
  end

  // Results are kept in a plain array; no reset needed on the data
  always_ff @(posedge sys_clk) begin
    if (convDone)
      result_ff[seqPos_ff] <= convResult;
  end

  // Overrun: writing a slot whose flag is still up loses old data
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      overrun_ff <= 1'b0;
    end else if (convDone && doneFlag_ff[seqPos_ff]) begin
      overrun_ff <= 1'b1;
    end else if (seqWrite) begin
      overrun_ff <= 1'b0;
    end else if (wrEn && paddr == acf_pkg::OFS_STATUS &&
                 pwdata[acf_pkg::STAT_OVERRUN_W1C]) begin
      overrun_ff <= 1'b0;
    end
  end

  // ==========================================================
  // Control, enables and sequence start pulse
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      dien_ff    <= acf_pkg::RST_DIEN;
      fastClr_ff <= 1'b0;
    end else if (wrEn) begin
      if (paddr == acf_pkg::OFS_DIEN_HIGH)
        dien_ff[15:8] <= pwdata[7:0];
      if (paddr == acf_pkg::OFS_DIEN_LOW)
        dien_ff[7:0] <= pwdata[7:0];
      if (paddr == acf_pkg::OFS_CTRL)
        fastClr_ff <= pwdata[acf_pkg::CTRL_FAST_CLR_BIT];
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b)
      seqStart_ff <= 1'b0;
    else
      seqStart_ff <= seqWrite;
  end

  // ==========================================================
  // Pin inputs: two stage sync before any gating
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pinSync1_ff <= acf_pkg::RST_PIN;
      pinSync2_ff <= acf_pkg::RST_PIN;
    end else begin
      pinSync1_ff <= analogInputPin;
      pinSync2_ff <= pinSync1_ff;
    end
  end

  // Disabled buffers read as one unless the channel is the trigger
  always_comb begin
    for (int i = 0; i < 16; i++) begin
      if (dien_ff[i] || (trigEnable && trigChannel == 4'(i)))
        pinView[i] = pinSync2_ff[i];
      else
        pinView[i] = 1'b1;
    end
  end

  // ==========================================================
  // Read data and response; writes to results fall through
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_ff  <= 32'h0000_0000;
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= psel && !pready_ff;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      if (psel && !pready_ff && !pwrite) begin
        if (is_result(paddr))
          prdata_ff <= {22'h000000, result_ff[res_index(paddr)]};
        else
          unique case (paddr)
            acf_pkg::OFS_DONE_HIGH:
              prdata_ff <= {24'h000000, doneFlag_ff[15:8]};
            acf_pkg::OFS_DONE_LOW:
              prdata_ff <= {24'h000000, doneFlag_ff[7:0]};
            acf_pkg::OFS_DIEN_HIGH: prdata_ff <= {24'h000000, dien_ff[15:8]};
            acf_pkg::OFS_DIEN_LOW:  prdata_ff <= {24'h000000, dien_ff[7:0]};
            acf_pkg::OFS_PIN_HIGH:  prdata_ff <= {24'h000000, pinView[15:8]};
            acf_pkg::OFS_PIN_LOW:   prdata_ff <= {24'h000000, pinView[7:0]};
            acf_pkg::OFS_CTRL:      prdata_ff <= {31'h0, fastClr_ff};
            acf_pkg::OFS_STATUS:
              prdata_ff <= {27'h0, overrun_ff, seqPos_ff};
            acf_pkg::OFS_SEQ_START: prdata_ff <= 32'h0000_0000;
            default:                pslverr_ff <= 1'b1;
          endcase
      end else if (psel && !pready_ff && pwrite && !is_result(paddr)) begin
        unique case (paddr)
          acf_pkg::OFS_DONE_HIGH, acf_pkg::OFS_DONE_LOW,
          acf_pkg::OFS_DIEN_HIGH, acf_pkg::OFS_DIEN_LOW,
          acf_pkg::OFS_PIN_HIGH,  acf_pkg::OFS_PIN_LOW,
          acf_pkg::OFS_CTRL,      acf_pkg::OFS_STATUS,
          acf_pkg::OFS_SEQ_START: pslverr_ff <= 1'b0;
          default:                pslverr_ff <= 1'b1;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs; buffer enable follows the bit, conversions ignored
  assign inputBufferEnable = dien_ff;
  assign prdata            = prdata_ff;
  assign pready            = pready_ff;
  assign pslverr           = pslverr_ff;
  assign seqStartPulse     = seqStart_ff;
  assign fastFlagClear     = fastClr_ff;

  // ==========================================================
  // Checks; all on the system clock, off while reset is held
  default clocking acfCb @(posedge sys_clk);
  endclocking
  default disable iff (!rst_b);

  // Flag set, clear and priority
  a_start_clears: assert property (
    seqWrite |=> doneFlag_ff == 16'h0000)
    else $error("sequence start did not clear flags");
  a_set_on_done: assert property (
    convDone && !seqWrite |=> doneFlag_ff[$past(seqPos_ff)])
    else $error("done flag not set at conversion end");
  a_set_beats_read: assert property (
    convDone && !seqWrite && rdClear[seqPos_ff]
    |=> doneFlag_ff[$past(seqPos_ff)])
    else $error("read clear beat a same cycle set");
  a_fast_read_clr: assert property (
    rdEn && resSel && fastClr_ff && !convDone && !seqWrite
    |=> !doneFlag_ff[$past(resIdx)])
    else $error("fast clear read left flag set");
  a_slow_armed_clr: assert property (
    rdEn && resSel && !fastClr_ff && armed_ff[resIdx] && !convDone &&
    !seqWrite |=> !doneFlag_ff[$past(resIdx)])
    else $error("armed result read left flag set");
  a_slow_no_clr: assert property (
    rdEn && resSel && !fastClr_ff && !armed_ff[resIdx] &&
    doneFlag_ff[resIdx] |=> doneFlag_ff[$past(resIdx)])
    else $error("unarmed result read cleared flag");
  a_arm_subset: assert property (
    (armed_ff & ~doneFlag_ff) == 16'h0000)
    else $error("clear armed for a flag that is not set");

  // Position counter and overrun
  a_pos_advance: assert property (
    convDone && !seqWrite |=> seqPos_ff == $past(seqPos_ff) + 4'h1)
    else $error("position counter did not advance");
  a_pos_wraps: assert property (
    convDone && !seqWrite && seqPos_ff == 4'hf |=> seqPos_ff == 4'h0)
    else $error("position counter did not wrap");
  a_overrun_set: assert property (
    convDone && doneFlag_ff[seqPos_ff] |=> overrun_ff)
    else $error("overrun not flagged");

  // Register side: status writes ignored, reads show the flags
  a_status_wr_nop: assert property (
    wrEn && paddr == acf_pkg::OFS_DONE_LOW && !convDone && !rdEn
    |=> doneFlag_ff == $past(doneFlag_ff))
    else $error("status write changed flags");
  a_read_low_flags: assert property (
    psel && !pready_ff && !pwrite && paddr == acf_pkg::OFS_DONE_LOW
    |=> prdata[7:0] == $past(doneFlag_ff[7:0]))
    else $error("low flag read returned wrong value");
  a_read_high_flags: assert property (
    psel && !pready_ff && !pwrite && paddr == acf_pkg::OFS_DONE_HIGH
    |=> prdata[7:0] == $past(doneFlag_ff[15:8]))
    else $error("high flag read returned wrong value");
  a_ready_answer: assert property (
    psel && !penable && !pready_ff |=> pready)
    else $error("setup cycle not answered");
  a_ready_pulse: assert property (
    pready |=> !pready)
    else $error("ready stood more than one cycle");
  a_seq_pulse: assert property (
    seqWrite |=> seqStartPulse)
    else $error("no start pulse after start write");

  // Pins and buffer enables
  a_pin_default: assert property (
    !dien_ff[0] && !(trigEnable && trigChannel == 4'h0) |-> pinView[0])
    else $error("disabled pin did not read one");
  a_enable_out: assert property (
    wrEn && paddr == acf_pkg::OFS_DIEN_LOW
    |=> inputBufferEnable[7:0] == $past(pwdata[7:0]))
    else $error("enable write not applied");
  a_buffer_steady: assert property (
    convDone && !wrEn |=> inputBufferEnable == $past(inputBufferEnable))
    else $error("conversion changed buffer enables");

  // Main scenarios worth seeing at least once
  c_fast_clear: cover property (rdEn && resSel && fastClr_ff);
  c_slow_clear: cover property (
    rdEn && resSel && !fastClr_ff && armed_ff[resIdx]);
  c_overrun: cover property (convDone && doneFlag_ff[seqPos_ff]);
  c_start_vs_set: cover property (seqWrite && convDone);
  c_trig_pin: cover property (trigEnable && !dien_ff[trigChannel]);

endmodule

// *** adc_completion_flags_tb.sv ***
/*
  Self-checking testbench for the conversion done flag block.
  Assumes acf_pkg and acf_completion_flags are compiled before it.
*/
`timescale 1ns/100ps
module adc_completion_flags_tb;
  // ==========================================================
  // Signals and bench model
  logic        sys_clk, rst_b, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, m;
  logic        convDone, trigEnable, seqStartPulse, fastFlagClear;
  logic [9:0]  convResult;
  logic [3:0]  trigChannel, cnt;
  logic [15:0] analogInputPin, inputBufferEnable, flg, en, p, lv;
  logic [9:0]  res [16];
  logic [32:0] e;
  logic [32:0] expQ [$];
  logic [31:0] mskQ [$];
  int          num_errors, n_compared;
  acf_completion_flags dut (
    .sys_clk(sys_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .convDone(convDone),
    .convResult(convResult), .trigEnable(trigEnable),
    .trigChannel(trigChannel), .analogInputPin(analogInputPin),
    .inputBufferEnable(inputBufferEnable), .seqStartPulse(seqStartPulse),
    .fastFlagClear(fastFlagClear));
  // ==========================================================
  // Clock, 100 MHz
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  // Watchdog, far beyond the two hundred or so cycles the tests take
  initial begin
    #200000;
    num_errors++;
    test_done();
  end
  // ==========================================================
  // Comparison and closing
  task automatic chk(string nm, logic [31:0] s, logic [31:0] x);
    n_compared++;
    if (s !== x) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, x, s);
    end
  endtask
  task automatic test_done();
    $display("Compared %0d, mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic endt(string nm);
    $display("Test %s done", nm);
  endtask
  // ==========================================================
  // APB master; the expected reply is noted before the request
  task automatic apb(logic w, logic [11:0] a, logic [31:0] d,
                     logic [31:0] x, logic [31:0] k, logic er);
    expQ.push_back({er, x});
    mskQ.push_back(k);
    @(posedge sys_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge sys_clk);
    penable <= 1'b1;
    // Request held until pready is sampled high; the watchdog ends a hang
    do begin
      @(posedge sys_clk);
    end while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(logic [11:0] a, logic [31:0] x);
    apb(1'b0, a, 32'h0, x, 32'hffffffff, 1'b0);
  endtask
  task automatic wr(logic [11:0] a, logic [31:0] d);
    apb(1'b1, a, d, 32'h0, 32'h0, 1'b0);
  endtask
  function automatic logic [11:0] ra(int i);
    return acf_pkg::OFS_RESULT0 + 12'(4 * i);
  endfunction
  // Sequence start write with its one-cycle pulse
  task automatic start();
    wr(acf_pkg::OFS_SEQ_START, 32'h0);
    #1 chk("seqStartPulse", {31'h0, seqStartPulse}, 32'h1);
  endtask
  // One conversion end at the current position
  task automatic conv();
    logic [9:0] v;
    v = 10'($urandom);
    @(posedge sys_clk);
    convDone   <= 1'b1;
    convResult <= v;
    @(posedge sys_clk);
    convDone <= 1'b0;
    flg[cnt] = 1'b1;
    res[cnt] = v;
    cnt      = cnt + 4'h1;
  endtask
  // ==========================================================
  // Reply monitor: oldest note against each answer
  always @(posedge sys_clk) begin
    if (psel && penable && pready === 1'b1) begin
      e = expQ.pop_front();
      m = mskQ.pop_front();
      chk("prdata", prdata & m, e[31:0] & m);
      chk("pslverr", {31'h0, pslverr}, {31'h0, e[32]});
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {psel, penable, pwrite, convDone, trigEnable, rst_b} = 6'h00;
    {paddr, pwdata, convResult, trigChannel} = 58'h0;
    analogInputPin = 16'h0;
    {flg, cnt} = 20'h0;
    void'($urandom(32'h2306));
    repeat (8) @(posedge sys_clk);
    rst_b <= 1'b1;
    rd(acf_pkg::OFS_DONE_HIGH, 32'h0);
    rd(acf_pkg::OFS_DIEN_LOW, 32'h0);
    rd(acf_pkg::OFS_PIN_LOW, 32'hff);
    rd(acf_pkg::OFS_STATUS, 32'h0);
    endt("reset");
    repeat (9) conv();
    rd(acf_pkg::OFS_DONE_LOW, 32'hff);
    rd(acf_pkg::OFS_DONE_HIGH, 32'h01);
    rd(acf_pkg::OFS_STATUS, 32'h9);
    // Status read then result read clears; an unarmed read does not
    rd(ra(8), {22'h0, res[8]});
    rd(acf_pkg::OFS_DONE_HIGH, 32'h00);
    conv();
    rd(ra(9), {22'h0, res[9]});
    rd(ra(8), {22'h0, res[8]});
    rd(acf_pkg::OFS_DONE_HIGH, 32'h02);
    rd(ra(9), {22'h0, res[9]});
    rd(acf_pkg::OFS_DONE_HIGH, 32'h00);
    wr(acf_pkg::OFS_DONE_LOW, 32'h0);
    rd(acf_pkg::OFS_DONE_LOW, 32'hff);
    endt("slow clear");
    wr(acf_pkg::OFS_CTRL, 32'h1);
    #1 chk("fastFlagClear", {31'h0, fastFlagClear}, 32'h1);
    rd(ra(0), {22'h0, res[0]});
    rd(acf_pkg::OFS_DONE_LOW, 32'hfe);
    repeat (8) conv();
    rd(acf_pkg::OFS_STATUS, 32'h12);
    wr(acf_pkg::OFS_STATUS, 32'h10);
    rd(acf_pkg::OFS_STATUS, 32'h02);
    endt("fast clear and overrun");
    // Start write and conversion end land on the same edge
    fork
      start();
      begin
        @(posedge sys_clk);
        conv();
      end
    join
    rd(acf_pkg::OFS_DONE_LOW, 32'h0);
    rd(acf_pkg::OFS_DONE_HIGH, 32'h0);
    start();
    rd(acf_pkg::OFS_STATUS, 32'h0);
    cnt = 4'h0;
    conv();
    // Result read clear and set of flag 1 on the same edge
    fork
      apb(1'b0, ra(1), 32'h0, 32'h0, 32'h0, 1'b0);
      begin
        @(posedge sys_clk);
        conv();
      end
    join
    rd(acf_pkg::OFS_DONE_LOW, 32'h03);
    endt("priority");
    en = 16'($urandom);
    p  = 16'($urandom);
    wr(acf_pkg::OFS_DIEN_HIGH, {24'h0, en[15:8]});
    wr(acf_pkg::OFS_DIEN_LOW, {24'h0, en[7:0]});
    #1 chk("inputBufferEnable", {16'h0, inputBufferEnable}, {16'h0, en});
    rd(acf_pkg::OFS_DIEN_HIGH, {24'h0, en[15:8]});
    analogInputPin <= p;
    conv();
    chk("inputBufferEnable", {16'h0, inputBufferEnable}, {16'h0, en});
    lv = (p & en) | ~en;
    rd(acf_pkg::OFS_PIN_HIGH, {24'h0, lv[15:8]});
    rd(acf_pkg::OFS_PIN_LOW, {24'h0, lv[7:0]});
    trigChannel <= 4'($urandom);
    trigEnable  <= 1'b1;
    repeat (3) @(posedge sys_clk);
    lv = (p & (en | (16'h1 << trigChannel))) | ~(en | (16'h1 << trigChannel));
    rd(acf_pkg::OFS_PIN_HIGH, {24'h0, lv[15:8]});
    rd(acf_pkg::OFS_PIN_LOW, {24'h0, lv[7:0]});
    apb(1'b0, 12'h030, 32'h0, 32'h0, 32'h0, 1'b1);
    endt("pins and map");
    @(posedge sys_clk);
    test_done();
  end
endmodule
